// file: verilog/lfc_top.sv
module lfc_top import lfc_pkg::*; (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        CPU_IN_BOOT,
  input  wire logic        ACC_STORE,
  input  wire logic        ACC_LOAD,
  input  wire logic        ACC_TGT_BOOT,
  output logic             ACC_DENY,
  output logic             IRQ_MASK,
  output logic             EEPROM_ERASE_EN,
  output logic             WATCHDOG_FORCED_ON,
  output logic             CLOCK_TO_PIN_EN,
  output logic [7:0]       EFF_HIGH,
  output logic [7:0]       EFF_LOW,
  output logic [7:0]       EFF_EXT
);
  // =====================================================
  // declarations
  // bus handshake
  logic        ack_q;
  logic        req;
  logic        wr;
  logic        rd;
  logic        ctrl_wr;
  logic        lock_wr;
  logic        erase;
  logic        fuse_wr_ok;
  // programming mode and its latch events
  lfc_mode_e   mode_q;
  lfc_mode_e   mode_d;
  logic        in_prog;
  logic        prog_rise;
  logic        prog_fall;
  logic        latch_now;
  logic        serial_q;
  logic        vboot_q;
  // raw fuse and lock bytes
  logic [7:0]  ext_small_q;
  logic [7:0]  ext_boot_q;
  logic [7:0]  high_q;
  logic [7:0]  high_d;
  logic [7:0]  low_q;
  logic [7:0]  lock_q;
  // latched copies seen by the rest of the chip
  logic [7:0]  eff_high_q;
  logic [7:0]  eff_low_q;
  logic [7:0]  eff_ext_q;
  // per-section decode, index 0 application, index 1 boot
  logic [1:0]  lock_lo;
  logic [1:0]  lock_hi;
  logic [1:0]  sec_exec;
  logic [1:0]  sec_tgt;
  logic [1:0]  sec_vec;
  logic [1:0]  sec_wr_block;
  logic [1:0]  sec_rd_block;
  logic [1:0]  sec_deny;
  logic [1:0]  sec_irq;
  lfc_prot_s   prot;
  // read back
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // =====================================================
  // bus handshake
  // one wait state: a request is seen in its first cycle and
  // answered in its second, so back to back requests take two cycles each
  assign req             = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign AVS_WAITREQUEST = req;

  // writes act only on the edge at which waitrequest is low
  assign wr = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];

  // reads are captured one edge early so the data stands
  // in the cycle in which waitrequest is low
  assign rd = AVS_READ & req;

  assign ctrl_wr = wr & (AVS_ADDRESS == LFC_OFF_CTRL);
  assign lock_wr = wr & (AVS_ADDRESS == LFC_OFF_LOCK);
  assign erase   = ctrl_wr & AVS_WRITEDATA[LFC_C_ERASE];

  // first memory lock bit programmed (zero) freezes every fuse byte
  assign fuse_wr_ok = wr & lock_q[LFC_B_MEM_LOCK_FIRST];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // =====================================================
  // programming mode
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      LFC_NORMAL: begin
        if (ctrl_wr && AVS_WRITEDATA[LFC_C_PROG]) begin
          mode_d = LFC_PROG;
        end
      end
      LFC_PROG: begin
        if (ctrl_wr && !AVS_WRITEDATA[LFC_C_PROG]) begin
          mode_d = LFC_NORMAL;
        end
      end
      default: begin
        mode_d = LFC_NORMAL;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q <= LFC_NORMAL;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign in_prog   = (mode_q == LFC_PROG);
  assign prog_rise = (mode_q == LFC_NORMAL) & (mode_d == LFC_PROG);
  assign prog_fall = (mode_q == LFC_PROG) & (mode_d == LFC_NORMAL);
  // entry snapshots the fuses, exit lets the session's changes through
  assign latch_now = prog_rise | prog_fall;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      serial_q <= 1'b0;
    end else if (ctrl_wr) begin
      serial_q <= AVS_WRITEDATA[LFC_C_SERIAL];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      vboot_q <= 1'b0;
    end else if (ctrl_wr) begin
      vboot_q <= AVS_WRITEDATA[LFC_C_VBOOT];
    end
  end

  // =====================================================
  // fuse bytes
  // no erase term anywhere below: chip erase leaves fuses alone
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_small_q <= LFC_RST_EXT_SMALL;
    end else if (fuse_wr_ok && AVS_ADDRESS == LFC_OFF_EXT_SMALL) begin
      ext_small_q <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_boot_q <= LFC_RST_EXT_BOOT;
    end else if (fuse_wr_ok && AVS_ADDRESS == LFC_OFF_EXT_BOOT) begin
      ext_boot_q <= AVS_WRITEDATA[7:0];
    end
  end

  // serial download bit keeps its value while in serial mode,
  // otherwise a serial session could lock itself out
  always_comb begin
    high_d = AVS_WRITEDATA[7:0];
    if (serial_q) begin
      high_d[LFC_B_SERIAL_DOWNLOAD] = high_q[LFC_B_SERIAL_DOWNLOAD];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      high_q <= LFC_RST_HIGH;
    end else if (fuse_wr_ok && AVS_ADDRESS == LFC_OFF_HIGH) begin
      high_q <= high_d;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_q <= LFC_RST_LOW;
    end else if (fuse_wr_ok && AVS_ADDRESS == LFC_OFF_LOW) begin
      low_q <= AVS_WRITEDATA[7:0];
    end
  end

  // =====================================================
  // lock bits
  // a write can only program (clear) bits; only erase brings them back
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_q <= LFC_RST_LOCK;
    end else if (erase) begin
      lock_q <= LFC_RST_LOCK;
    end else if (lock_wr) begin
      lock_q <= (lock_q & AVS_WRITEDATA[7:0]) | LFC_LOCK_KEEP;
    end
  end

  // =====================================================
  // latched copies
  // reset stands for power-up in normal mode; between latch events
  // the copies hold, so clock and watchdog settings never wander
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      eff_high_q <= LFC_RST_HIGH;
    end else if (latch_now) begin
      eff_high_q <= high_q;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      eff_low_q <= LFC_RST_LOW;
    end else if (latch_now) begin
      eff_low_q <= low_q;
    end
  end

  // the boot variant byte is the one this build decodes
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      eff_ext_q <= LFC_RST_EXT_BOOT;
    end else if (latch_now) begin
      eff_ext_q <= ext_boot_q;
    end
  end

  assign EFF_HIGH = eff_high_q;
  assign EFF_LOW  = eff_low_q;
  assign EFF_EXT  = eff_ext_q;

  // =====================================================
  // fuse driven outputs
  // eeprom preserve uses the live fuse, never the latched copy
  assign EEPROM_ERASE_EN    = high_q[LFC_B_EEPROM_PRESERVE];
  assign WATCHDOG_FORCED_ON = ~eff_high_q[LFC_B_WATCHDOG_FORCED];
  assign CLOCK_TO_PIN_EN    = ~eff_low_q[LFC_B_CLOCK_TO_PIN];

  // =====================================================
  // lock decode, same cycle as the access
  assign lock_lo  = {lock_q[LFC_B_BOOT_LOCK_LO], lock_q[LFC_B_APP_LOCK_LO]};
  assign lock_hi  = {lock_q[LFC_B_BOOT_LOCK_HI], lock_q[LFC_B_APP_LOCK_HI]};
  assign sec_exec = {CPU_IN_BOOT, ~CPU_IN_BOOT};
  assign sec_tgt  = {ACC_TGT_BOOT, ~ACC_TGT_BOOT};
  assign sec_vec  = {vboot_q, ~vboot_q};

  for (genvar g = 0; g < 2; g++) begin : g_sec
    // low lock bit programmed: stores into the section refused
    assign sec_wr_block[g] = ~lock_lo[g];
    // high lock bit programmed: loads from the other section refused
    assign sec_rd_block[g] = ~lock_hi[g];
    // loads inside their own section are never blocked
    assign sec_deny[g] = sec_tgt[g] &
                         ((ACC_STORE & sec_wr_block[g]) |
                          (ACC_LOAD & ~sec_exec[g] & sec_rd_block[g]));
    // vectors in the other section would leak a read-locked one
    assign sec_irq[g]  = sec_rd_block[g] & sec_exec[g] & ~sec_vec[g];
  end

  assign ACC_DENY = |sec_deny;
  assign IRQ_MASK = |sec_irq;

  always_comb begin
    prot.app_wr_block  = sec_wr_block[0];
    prot.app_rd_block  = sec_rd_block[0];
    prot.boot_wr_block = sec_wr_block[1];
    prot.boot_rd_block = sec_rd_block[1];
  end

  // =====================================================
  // read back
  // fuses read raw: zero means programmed; erase strobe reads zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (AVS_ADDRESS)
      LFC_OFF_EXT_SMALL: rdata_d = {24'h000000, ext_small_q};
      LFC_OFF_EXT_BOOT:  rdata_d = {24'h000000, ext_boot_q};
      LFC_OFF_HIGH:      rdata_d = {24'h000000, high_q};
      LFC_OFF_LOW:       rdata_d = {24'h000000, low_q};
      LFC_OFF_LOCK:      rdata_d = {24'h000000, lock_q};
      LFC_OFF_CTRL:      rdata_d = {28'h0000000, vboot_q, 1'b0, serial_q, in_prog};
      LFC_OFF_STATUS:    rdata_d = {28'h0000000, prot.app_wr_block, prot.app_rd_block,
                                    prot.boot_wr_block, prot.boot_rd_block};
      LFC_OFF_EFF_HIGH:  rdata_d = {24'h000000, eff_high_q};
      LFC_OFF_EFF_LOW:   rdata_d = {24'h000000, eff_low_q};
      LFC_OFF_EFF_EXT:   rdata_d = {24'h000000, eff_ext_q};
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  // data held until the next read, so a slow master still sees it
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign AVS_READDATA = rdata_q;
endmodule // lfc_top

// file: verilog/lfc_pkg.sv
package lfc_pkg;
  // =====================================================
  // register map
  localparam logic [3:0] LFC_OFF_EXT_SMALL = 4'h0;
  localparam logic [3:0] LFC_OFF_EXT_BOOT  = 4'h1;
  localparam logic [3:0] LFC_OFF_HIGH      = 4'h2;
  localparam logic [3:0] LFC_OFF_LOW       = 4'h3;
  localparam logic [3:0] LFC_OFF_LOCK      = 4'h4;
  localparam logic [3:0] LFC_OFF_CTRL      = 4'h5;
  localparam logic [3:0] LFC_OFF_STATUS    = 4'h6;
  localparam logic [3:0] LFC_OFF_EFF_HIGH  = 4'h7;
  localparam logic [3:0] LFC_OFF_EFF_LOW   = 4'h8;
  localparam logic [3:0] LFC_OFF_EFF_EXT   = 4'h9;
  // =====================================================
  // reset values
  localparam logic [7:0] LFC_RST_EXT_SMALL = 8'hFF;
  localparam logic [7:0] LFC_RST_EXT_BOOT  = 8'hF9;
  localparam logic [7:0] LFC_RST_HIGH      = 8'hDF;
  localparam logic [7:0] LFC_RST_LOW       = 8'h62;
  localparam logic [7:0] LFC_RST_LOCK      = 8'hFF;
  // =====================================================
  // field positions
  localparam int LFC_B_MEM_LOCK_FIRST  = 0;
  localparam int LFC_B_MEM_LOCK_SECOND = 1;
  localparam int LFC_B_APP_LOCK_LO     = 2;
  localparam int LFC_B_APP_LOCK_HI     = 3;
  localparam int LFC_B_BOOT_LOCK_LO    = 4;
  localparam int LFC_B_BOOT_LOCK_HI    = 5;
  localparam int LFC_B_EEPROM_PRESERVE = 3;
  localparam int LFC_B_WATCHDOG_FORCED = 4;
  localparam int LFC_B_SERIAL_DOWNLOAD = 5;
  localparam int LFC_B_CLOCK_TO_PIN    = 6;
  localparam logic [7:0] LFC_LOCK_KEEP = 8'hC0;
  // ctrl: 0 prog mode, 1 serial mode, 2 chip erase strobe, 3 vectors in boot
  localparam int LFC_C_PROG   = 0;
  localparam int LFC_C_SERIAL = 1;
  localparam int LFC_C_ERASE  = 2;
  localparam int LFC_C_VBOOT  = 3;
  // =====================================================
  // types
  typedef struct packed {
    logic app_wr_block;
    logic app_rd_block;
    logic boot_wr_block;
    logic boot_rd_block;
  } lfc_prot_s;
  typedef enum logic [1:0] {
    LFC_NORMAL = 2'b00,
    LFC_PROG   = 2'b01
  } lfc_mode_e;
endpackage : lfc_pkg

// file: verification/lfc_top_checker.sv
// =====================================================
// port checker
module lfc_top_checker import lfc_pkg::*; (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        CPU_IN_BOOT,
  input wire logic        ACC_STORE,
  input wire logic        ACC_LOAD,
  input wire logic        ACC_TGT_BOOT,
  input wire logic        ACC_DENY,
  input wire logic        IRQ_MASK,
  input wire logic        WATCHDOG_FORCED_ON,
  input wire logic        CLOCK_TO_PIN_EN,
  input wire logic [7:0]  EFF_HIGH,
  input wire logic [7:0]  EFF_LOW
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  chk_read_answer:
    assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("read answer late");
  chk_upper_zero:
    assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0) else $error("upper bits set");
  chk_unmapped_zero:
    assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > 4'h9 |-> AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
  chk_watchdog_fuse:
    assert property (WATCHDOG_FORCED_ON == !EFF_HIGH[LFC_B_WATCHDOG_FORCED]) else $error("watchdog force wrong");
  chk_clock_pin:
    assert property (CLOCK_TO_PIN_EN == !EFF_LOW[LFC_B_CLOCK_TO_PIN]) else $error("clock pin wrong");
  chk_fuse_hold:
    assert property ($changed({EFF_HIGH, EFF_LOW}) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2)
      || $past(AVS_WRITE, 3) || $past(AVS_WRITE, 4)) else $error("fuse copy moved");
  chk_app_self:
    assert property (ACC_LOAD && !ACC_STORE && !CPU_IN_BOOT && !ACC_TGT_BOOT |-> !ACC_DENY)
      else $error("app self load denied");
  chk_boot_self:
    assert property (ACC_LOAD && !ACC_STORE && CPU_IN_BOOT && ACC_TGT_BOOT |-> !ACC_DENY)
      else $error("boot self load denied");
  cover property (ACC_DENY);
  cover property (IRQ_MASK);
  cover property ($changed(EFF_LOW));
  cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule // lfc_top_checker

// file: verification/tb.sv
module tb import lfc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        REF_CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, CPU_IN_BOOT, ACC_STORE, ACC_LOAD;
  logic        ACC_TGT_BOOT, ACC_DENY, IRQ_MASK, EEPROM_ERASE_EN, WATCHDOG_FORCED_ON, CLOCK_TO_PIN_EN;
  logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic [7:0]  EFF_HIGH, EFF_LOW, EFF_EXT, rd;
  int          err_count, cmp_count;
  lfc_top i_dut (
    .REF_CLK            (REF_CLK),
    .RST_N              (RST_N),
    .AVS_ADDRESS        (AVS_ADDRESS),
    .AVS_READ           (AVS_READ),
    .AVS_WRITE          (AVS_WRITE),
    .AVS_WRITEDATA      (AVS_WRITEDATA),
    .AVS_BYTEENABLE     (AVS_BYTEENABLE),
    .AVS_READDATA       (AVS_READDATA),
    .AVS_WAITREQUEST    (AVS_WAITREQUEST),
    .CPU_IN_BOOT        (CPU_IN_BOOT),
    .ACC_STORE          (ACC_STORE),
    .ACC_LOAD           (ACC_LOAD),
    .ACC_TGT_BOOT       (ACC_TGT_BOOT),
    .ACC_DENY           (ACC_DENY),
    .IRQ_MASK           (IRQ_MASK),
    .EEPROM_ERASE_EN    (EEPROM_ERASE_EN),
    .WATCHDOG_FORCED_ON (WATCHDOG_FORCED_ON),
    .CLOCK_TO_PIN_EN    (CLOCK_TO_PIN_EN),
    .EFF_HIGH           (EFF_HIGH),
    .EFF_LOW            (EFF_LOW),
    .EFF_EXT            (EFF_EXT)
  );
  always #20 REF_CLK = ~REF_CLK;
  // =====================================================
  // shared tasks
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge REF_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    rd = AVS_READDATA[7:0];
    if (n >= 50) check("waitrequest", 1'b0, 1'b1);
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string nm);
    bus(1'b0, a, 8'h00);
    check(nm, exp, rd);
  endtask
  // =====================================================
  // scenarios
  task automatic t_reset;
    rdchk(LFC_OFF_EXT_SMALL, LFC_RST_EXT_SMALL, "ext_small");
    rdchk(LFC_OFF_EXT_BOOT, LFC_RST_EXT_BOOT, "ext_boot");
    rdchk(LFC_OFF_HIGH, LFC_RST_HIGH, "high");
    rdchk(LFC_OFF_LOW, LFC_RST_LOW, "low");
    rdchk(4'hC, 8'h00, "unmapped");
    check("eff_high", LFC_RST_HIGH, EFF_HIGH);
    check("eff_low", LFC_RST_LOW, EFF_LOW);
    check("eff_ext", LFC_RST_EXT_BOOT, EFF_EXT);
    check("ee_erase", 1'b1, EEPROM_ERASE_EN);
    $display("done: reset values");
  endtask
  // every lock code, every access kind, both vector places
  task automatic t_locks;
    logic [3:0] l;
    for (int c = 0; c < 16; c++) begin
      l = c[3:0];
      bus(1'b1, LFC_OFF_CTRL, 8'h04);
      bus(1'b1, LFC_OFF_LOCK, {2'b11, l, 2'b11});
      bus(1'b1, LFC_OFF_LOCK, 8'hFF);
      rdchk(LFC_OFF_LOCK, {2'b11, l, 2'b11}, "lock");
      rdchk(LFC_OFF_STATUS, {4'h0, !l[0], !l[1], !l[2], !l[3]}, "status");
      for (int k = 0; k < 16; k++) begin
        if (k[2:0] == 3'h0) bus(1'b1, LFC_OFF_CTRL, {4'h0, k[3], 3'h0});
        @(posedge REF_CLK);
        CPU_IN_BOOT <= k[2];
        ACC_STORE <= k[1];
        ACC_LOAD <= !k[1];
        ACC_TGT_BOOT <= k[0];
        @(negedge REF_CLK);
        check("deny", k[0] ? (k[1] ? !l[2] : (!k[2] && !l[3])) : (k[1] ? !l[0] : (k[2] && !l[1])), ACC_DENY);
        check("irq", (!l[1] && k[3] && !k[2]) || (!l[3] && !k[3] && k[2]), IRQ_MASK);
      end
    end
    $display("done: lock modes");
  endtask
  task automatic t_fuses;
    bus(1'b1, LFC_OFF_CTRL, 8'h01);
    bus(1'b1, LFC_OFF_LOW, 8'h22);
    bus(1'b1, LFC_OFF_HIGH, 8'hC7);
    bus(1'b1, LFC_OFF_EXT_BOOT, 8'hF8);
    rdchk(LFC_OFF_CTRL, 8'h01, "ctrl");
    rdchk(LFC_OFF_EFF_LOW, LFC_RST_LOW, "eff_low_reg");
    check("eff_ext", LFC_RST_EXT_BOOT, EFF_EXT);
    check("eff_low", LFC_RST_LOW, EFF_LOW);
    check("clk_pin", 1'b0, CLOCK_TO_PIN_EN);
    check("ee_erase", 1'b0, EEPROM_ERASE_EN);
    bus(1'b1, LFC_OFF_CTRL, 8'h00);
    repeat (3) @(posedge REF_CLK);
    check("eff_low", 8'h22, EFF_LOW);
    check("clk_pin", 1'b1, CLOCK_TO_PIN_EN);
    check("wdt_on", 1'b1, WATCHDOG_FORCED_ON);
    check("eff_ext", 8'hF8, EFF_EXT);
    rdchk(LFC_OFF_EFF_HIGH, 8'hC7, "eff_high_reg");
    bus(1'b1, LFC_OFF_CTRL, 8'h04);
    rdchk(LFC_OFF_LOW, 8'h22, "low");
    rdchk(LFC_OFF_CTRL, 8'h00, "ctrl");
    bus(1'b1, LFC_OFF_CTRL, 8'h02);
    bus(1'b1, LFC_OFF_HIGH, 8'hFF);
    rdchk(LFC_OFF_HIGH, 8'hDF, "high");
    rdchk(LFC_OFF_CTRL, 8'h02, "ctrl");
    check("eff_high", 8'hC7, EFF_HIGH);
    bus(1'b1, LFC_OFF_CTRL, 8'h00);
    bus(1'b1, LFC_OFF_LOCK, 8'hFE);
    bus(1'b1, LFC_OFF_LOW, LFC_RST_LOW);
    rdchk(LFC_OFF_LOW, 8'h22, "low");
    $display("done: fuses");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // =====================================================
  // main sequence and watchdog
  initial begin
    {REF_CLK, RST_N, AVS_READ, AVS_WRITE, CPU_IN_BOOT, ACC_STORE, ACC_LOAD, ACC_TGT_BOOT} = 8'h00;
    {AVS_ADDRESS, AVS_WRITEDATA, AVS_BYTEENABLE} = {4'h0, 32'h0, 4'hF};
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    t_reset;
    t_locks;
    t_fuses;
    give_verdict;
  end
  // whole run needs about 670 cycles
  initial begin
    #400000;
    err_count++;
    give_verdict;
  end
endmodule // tb
bind lfc_top lfc_top_checker i_chk (
  .REF_CLK            (REF_CLK),
  .RST_N              (RST_N),
  .AVS_ADDRESS        (AVS_ADDRESS),
  .AVS_READ           (AVS_READ),
  .AVS_WRITE          (AVS_WRITE),
  .AVS_READDATA       (AVS_READDATA),
  .AVS_WAITREQUEST    (AVS_WAITREQUEST),
  .CPU_IN_BOOT        (CPU_IN_BOOT),
  .ACC_STORE          (ACC_STORE),
  .ACC_LOAD           (ACC_LOAD),
  .ACC_TGT_BOOT       (ACC_TGT_BOOT),
  .ACC_DENY           (ACC_DENY),
  .IRQ_MASK           (IRQ_MASK),
  .WATCHDOG_FORCED_ON (WATCHDOG_FORCED_ON),
  .CLOCK_TO_PIN_EN    (CLOCK_TO_PIN_EN),
  .EFF_HIGH           (EFF_HIGH),
  .EFF_LOW            (EFF_LOW)
);
